// ==== common/ddp_pkg.sv ====
// ddp_pkg: constants and types of the dual data pointer unit.
// assumes one core clock shared by the unit, the decoder and the sfr bus.
package ddp_pkg;

    // special function register addresses
    localparam logic [7:0] DDP_ADDR_ACT_LOW = 8'h82;
    localparam logic [7:0] DDP_ADDR_ACT_HIGH = 8'h83;
    localparam logic [7:0] DDP_ADDR_ALT_LOW = 8'hD4;
    localparam logic [7:0] DDP_ADDR_ALT_HIGH = 8'hD5;
    localparam logic [7:0] DDP_ADDR_CONFIG = 8'hA1;
    localparam logic [7:0] DDP_ADDR_AUX_ONE = 8'hA2;

    // auxiliary_control_one fields
    localparam int DDP_AUX_SEL_BIT = 0;
    localparam int DDP_AUX_ZERO_BIT = 2;

    // pointer_config_register fields
    localparam int DDP_CFG_UPD0_BIT = 0;
    localparam int DDP_CFG_UPD1_BIT = 1;
    localparam int DDP_CFG_DOWN0_BIT = 2;
    localparam int DDP_CFG_DOWN1_BIT = 3;

    // reset values
    localparam logic [15:0] DDP_PTR_RESET = 16'h0000;
    localparam logic [7:0] DDP_AUX_RESET = 8'h00;
    localparam logic [7:0] DDP_CFG_RESET = 8'h00;

    // value of the per-instruction inverse-select prefix byte
    localparam logic [7:0] DDP_PREFIX_OPCODE = 8'hA5;

    // pointer operations issued by the instruction decoder
    typedef enum logic [2:0] {
        DDP_OP_PREFIX,
        DDP_OP_LOAD,
        DDP_OP_INC,
        DDP_OP_MOVE,
        DDP_OP_JUMP
    } ddp_op_type;

    typedef struct packed {
        logic valid;
        ddp_op_type code;
        logic [15:0] data;
    } ddp_op_req_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ddp_sfr_req_type;

endpackage

// ==== verilog/ddp_unit.sv ====
// ddp_unit: two 16-bit data pointers with select, prefix and auto-update.
// assumes the decoder and sfr bus run on i_clock and issue one op per cycle.
`timescale 1ns/1ns
module ddp_unit
    import ddp_pkg::*;
#(
    parameter int PTR_WIDTH = 16
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // instruction decoder
    input wire ddp_op_req_type i_op,
    // sfr bus
    input wire ddp_sfr_req_type i_sfr,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_rvalid,
    // pointer state and access address
    output logic [PTR_WIDTH-1:0] o_ptr_zero,
    output logic [PTR_WIDTH-1:0] o_ptr_one,
    output logic o_pointer_select,
    output logic [PTR_WIDTH-1:0] o_access_addr,
    output logic o_access_valid
);

    logic [PTR_WIDTH-1:0] ptr_q [2];
    logic [PTR_WIDTH-1:0] ptr_d [2];
    logic [7:0] aux_q;
    logic [7:0] aux_d;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic prefix_q;
    logic prefix_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [PTR_WIDTH-1:0] acc_addr_q;
    logic [PTR_WIDTH-1:0] acc_addr_d;
    logic acc_valid_q;
    logic acc_valid_d;

    logic sel;
    logic eff;
    logic [PTR_WIDTH-1:0] eff_ptr;
    logic [PTR_WIDTH-1:0] stepped;
    logic down_eff;
    logic upd_eff;
    logic [PTR_WIDTH-1:0] act_ptr;
    logic [PTR_WIDTH-1:0] alt_ptr;

    always_comb begin
        sel = aux_q[DDP_AUX_SEL_BIT];
        // jump and sfr accesses never see the prefix; every other op does
        if (i_op.code == DDP_OP_JUMP) begin
            eff = sel;
        end else begin
            eff = sel ^ prefix_q;
        end
        eff_ptr = ptr_q[eff];
        down_eff = eff ? cfg_q[DDP_CFG_DOWN1_BIT] : cfg_q[DDP_CFG_DOWN0_BIT];
        upd_eff = eff ? cfg_q[DDP_CFG_UPD1_BIT] : cfg_q[DDP_CFG_UPD0_BIT];
        // modulo wrap comes from the fixed width
        if (down_eff) begin
            stepped = eff_ptr - 1'b1;
        end else begin
            stepped = eff_ptr + 1'b1;
        end
        act_ptr = ptr_q[sel];
        alt_ptr = ptr_q[~sel];
    end

    // sfr writes, then decoder ops; an op in the same cycle wins a pointer
    always_comb begin
        ptr_d[0] = ptr_q[0];
        ptr_d[1] = ptr_q[1];
        aux_d = aux_q;
        cfg_d = cfg_q;
        prefix_d = prefix_q;
        acc_addr_d = acc_addr_q;
        acc_valid_d = 1'b0;
        if (i_sfr.wr) begin
            unique case (i_sfr.addr)
                DDP_ADDR_ACT_LOW: ptr_d[sel][7:0] = i_sfr.wdata;
                DDP_ADDR_ACT_HIGH: ptr_d[sel][15:8] = i_sfr.wdata;
                DDP_ADDR_ALT_LOW: ptr_d[~sel][7:0] = i_sfr.wdata;
                DDP_ADDR_ALT_HIGH: ptr_d[~sel][15:8] = i_sfr.wdata;
                DDP_ADDR_AUX_ONE: begin
                    aux_d = i_sfr.wdata;
                    aux_d[DDP_AUX_ZERO_BIT] = 1'b0;
                end
                DDP_ADDR_CONFIG: cfg_d = i_sfr.wdata;
                default: ;
            endcase
        end
        if (i_op.valid) begin
            prefix_d = 1'b0;
            unique case (i_op.code)
                DDP_OP_PREFIX: prefix_d = 1'b1;
                DDP_OP_LOAD: ptr_d[eff] = i_op.data;
                DDP_OP_INC: ptr_d[eff] = stepped;
                DDP_OP_MOVE: begin
                    acc_addr_d = eff_ptr;
                    acc_valid_d = 1'b1;
                    if (upd_eff) begin
                        ptr_d[eff] = stepped;
                    end
                end
                DDP_OP_JUMP: begin
                    acc_addr_d = eff_ptr;
                    acc_valid_d = 1'b1;
                end
                // codes past the last op are illegal and only clear the prefix
                default: ;
            endcase
        end
    end

    always_comb begin
        rvalid_d = i_sfr.rd;
        rdata_d = 8'h00;
        if (i_sfr.rd) begin
            unique case (i_sfr.addr)
                DDP_ADDR_ACT_LOW: rdata_d = act_ptr[7:0];
                DDP_ADDR_ACT_HIGH: rdata_d = act_ptr[15:8];
                DDP_ADDR_ALT_LOW: rdata_d = alt_ptr[7:0];
                DDP_ADDR_ALT_HIGH: rdata_d = alt_ptr[15:8];
                DDP_ADDR_AUX_ONE: rdata_d = aux_q;
                DDP_ADDR_CONFIG: rdata_d = cfg_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ptr_q[0] <= DDP_PTR_RESET;
            ptr_q[1] <= DDP_PTR_RESET;
            aux_q <= DDP_AUX_RESET;
            cfg_q <= DDP_CFG_RESET;
            prefix_q <= 1'b0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            acc_addr_q <= DDP_PTR_RESET;
            acc_valid_q <= 1'b0;
        end else begin
            ptr_q[0] <= ptr_d[0];
            ptr_q[1] <= ptr_d[1];
            aux_q <= aux_d;
            cfg_q <= cfg_d;
            prefix_q <= prefix_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            acc_addr_q <= acc_addr_d;
            acc_valid_q <= acc_valid_d;
        end
    end

    assign o_ptr_zero = ptr_q[0];
    assign o_ptr_one = ptr_q[1];
    assign o_pointer_select = aux_q[DDP_AUX_SEL_BIT];
    assign o_sfr_rdata = rdata_q;
    assign o_sfr_rvalid = rvalid_q;
    assign o_access_addr = acc_addr_q;
    assign o_access_valid = acc_valid_q;

endmodule

// ==== verification/ddp_unit_sva.sv ====
// ddp_unit_sva: port timing checks of the pointer unit.
// assumes one clock domain and the active-high async reset.
`timescale 1ns/1ns
module ddp_unit_sva
    import ddp_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // watched ports
    input wire ddp_op_req_type i_op,
    input wire ddp_sfr_req_type i_sfr,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_sfr_rvalid,
    input wire logic [15:0] o_ptr_zero,
    input wire logic [15:0] o_ptr_one,
    input wire logic o_pointer_select,
    input wire logic [15:0] o_access_addr,
    input wire logic o_access_valid
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    wire logic [15:0] act = o_pointer_select ? o_ptr_one : o_ptr_zero;
    wire logic [15:0] alt = o_pointer_select ? o_ptr_zero : o_ptr_one;
    wire logic rd = i_sfr.rd;
    wire logic jmp = i_op.valid && i_op.code == DDP_OP_JUMP;
    wire logic mvj = jmp || (i_op.valid && i_op.code == DDP_OP_MOVE);
    read_pulse_a: assert property (o_sfr_rvalid == $past(rd))
        else $error("rvalid not one cycle after rd");
    act_read_a: assert property (rd && i_sfr.addr == DDP_ADDR_ACT_LOW
        |=> o_sfr_rdata == $past(act[7:0])) else $error("bad 82 read");
    alt_read_a: assert property (rd && i_sfr.addr == DDP_ADDR_ALT_HIGH
        |=> o_sfr_rdata == $past(alt[15:8])) else $error("bad D5 read");
    aux_zero_a: assert property (rd && i_sfr.addr == DDP_ADDR_AUX_ONE
        |=> !o_sfr_rdata[DDP_AUX_ZERO_BIT]) else $error("aux bit2 set");
    act_write_a: assert property (i_sfr.wr && !i_op.valid &&
        i_sfr.addr == DDP_ADDR_ACT_LOW |=> act[7:0] == $past(i_sfr.wdata))
        else $error("82 write missed");
    ptr_hold_a: assert property (!i_op.valid && !i_sfr.wr |=>
        $stable(o_ptr_zero) && $stable(o_ptr_one)) else $error("ptr moved");
    access_a: assert property (o_access_valid == $past(mvj))
        else $error("access pulse wrong");
    jump_ptr_a: assert property (jmp |=> o_access_addr == $past(act))
        else $error("jump used wrong pointer");
    cover property (rd);
    cover property (mvj);
    cover property (i_op.valid && i_op.code == DDP_OP_PREFIX ##2 jmp);
endmodule
bind ddp_unit ddp_unit_sva u_sva(.*);

// ==== verification/ddp_host.sv ====
// ddp_host: decoder and sfr bus model, one request at a time.
// assumes it shares i_clock with the unit; answers read after the edge.
`timescale 1ns/1ns
module ddp_host
    import ddp_pkg::*;
(
    // clock and answer
    input wire logic i_clock,
    input wire logic [7:0] i_rdata,
    // requests
    output ddp_op_req_type o_op,
    output ddp_sfr_req_type o_sfr
);
    initial begin
        o_op = '0;
        o_sfr = '0;
    end
    task automatic sfr(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
        @(posedge i_clock);
        o_sfr <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_clock);
        o_sfr <= '0;
        #1 q = i_rdata;
    endtask
    task automatic op(input ddp_op_type c, input logic [15:0] d);
        @(posedge i_clock);
        o_op <= '{valid: 1'b1, code: c, data: d};
        @(posedge i_clock);
        o_op <= '0;
        #1;
    endtask
endmodule

// ==== verification/ddp_unit_test.sv ====
// ddp_unit_test: self-checking bench of the pointer unit.
// assumes ddp_host drives requests and the checker is bound.
`timescale 1ns/1ns
module ddp_unit_test;
    import ddp_pkg::*;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    ddp_op_req_type op;
    ddp_sfr_req_type sfr;
    logic [7:0] rdata, q;
    logic rvalid, sel, acc_v;
    logic [15:0] p0, p1, acc;
    int fails = 0;
    int check_count = 0;
    ddp_unit u_dut(.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_op(op),
        .i_sfr(sfr), .o_sfr_rdata(rdata), .o_sfr_rvalid(rvalid),
        .o_ptr_zero(p0), .o_ptr_one(p1), .o_pointer_select(sel),
        .o_access_addr(acc), .o_access_valid(acc_v));
    ddp_host u_host(.i_clock(i_clock), .i_rdata(rdata), .o_op(op),
        .o_sfr(sfr));
    initial forever #5 i_clock = ~i_clock;
    task automatic chk(string n, logic [15:0] g, logic [15:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_regs();
        u_host.sfr(1, DDP_ADDR_ACT_LOW, 8'h34, q);
        u_host.sfr(1, DDP_ADDR_ACT_HIGH, 8'h12, q);
        chk("ptr0", p0, 16'h1234);
        u_host.sfr(0, DDP_ADDR_ACT_LOW, 8'h00, q);
        chk("act low", {8'h00, q}, 16'h0034);
        u_host.sfr(1, DDP_ADDR_ALT_HIGH, 8'hAB, q);
        chk("ptr1", p1, 16'hAB00);
        u_host.sfr(0, DDP_ADDR_ALT_HIGH, 8'h00, q);
        chk("alt high", {8'h00, q}, 16'h00AB);
        $display("t_regs done");
    endtask
    task automatic t_sel();
        u_host.sfr(1, DDP_ADDR_AUX_ONE, 8'hFF, q);
        u_host.sfr(0, DDP_ADDR_AUX_ONE, 8'h00, q);
        chk("aux", {8'h00, q}, 16'h00FB);
        u_host.sfr(0, DDP_ADDR_ACT_HIGH, 8'h00, q);
        chk("swap", {8'h00, q}, 16'h00AB);
        u_host.sfr(1, DDP_ADDR_AUX_ONE, 8'hFC, q);
        chk("sel", {15'h0000, sel}, 16'h0000);
        $display("t_sel done");
    endtask
    task automatic t_ops();
        u_host.op(DDP_OP_LOAD, 16'h0000);
        u_host.op(DDP_OP_PREFIX, '0);
        u_host.op(DDP_OP_LOAD, 16'hFFFF);
        chk("load", p0, 16'h0000);
        chk("load inv", p1, 16'hFFFF);
        u_host.op(DDP_OP_INC, '0);
        chk("inc", p0, 16'h0001);
        u_host.op(DDP_OP_PREFIX, '0);
        u_host.op(DDP_OP_INC, '0);
        chk("wrap", p1, 16'h0000);
        u_host.sfr(1, DDP_ADDR_CONFIG, 8'h05, q);
        u_host.sfr(0, DDP_ADDR_CONFIG, 8'h00, q);
        chk("cfg", {8'h00, q}, 16'h0005);
        u_host.op(DDP_OP_INC, '0);
        chk("dec", p0, 16'h0000);
        u_host.op(DDP_OP_MOVE, '0);
        chk("move addr", acc, 16'h0000);
        chk("post dec", p0, 16'hFFFF);
        u_host.op(DDP_OP_PREFIX, '0);
        u_host.op(DDP_OP_JUMP, '0);
        chk("jump", acc, 16'hFFFF);
        u_host.sfr(1, DDP_ADDR_CONFIG, 8'h00, q);
        $display("t_ops done");
    endtask
    initial begin
        repeat (20) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_regs();
        t_sel();
        t_ops();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge i_clock);
        fails++;
        print_verdict();
    end
endmodule
